/* design/cadp_pkg.sv */
// Shared constants and types for the card address decode and status pin block.
package cadp_pkg;

    typedef enum logic [1:0] {
        MODE_PC_MEMORY,
        MODE_PC_IO,
        MODE_IDE_COMPATIBLE,
        MODE_UNUSED
    } cadp_mode_t;

    typedef enum logic [2:0] {
        SPACE_NONE,
        SPACE_CARD_INFO,
        SPACE_CONFIG_STATUS,
        SPACE_MEMORY_REGS,
        SPACE_IO_REGS,
        SPACE_TASKFILE,
        SPACE_CONTROL_BLOCK
    } cadp_space_t;

    typedef enum logic [2:0] {
        HS_IDLE,
        HS_SLAVE_ANNOUNCE,
        HS_MASTER_WAIT_PRESENT,
        HS_MASTER_WAIT_PASS,
        HS_DONE
    } cadp_hs_t;

    localparam int ADDR_W = 11;
    localparam int TF_IDX_W = 3;
    localparam int TIMER_W = 32;

    // Attribute space: bytes below this offset hold card information.
    localparam logic [10:0] CONFIG_SPACE_BASE = 11'h200;

    // Control block holds two task file slots, selected by the low address bits.
    localparam logic [2:0] CTRL_ALT_STATUS_IDX = 3'h6;

    // Insertion detect pins are grounded in every mode.
    localparam logic [1:0] INSERTION_DETECT_LEVEL = 2'h0;

    // Handshake windows, in milliseconds, with cycle counts at 100 MHz.
    localparam longint CLK_HZ = 100000000;
    localparam longint PRESENCE_WINDOW_MS = 450;
    localparam longint PASS_WINDOW_MS = 31000;
    localparam longint SLAVE_ACTIVE_HOLD_MS = 30000;
    localparam longint PRESENCE_WINDOW_CYC = PRESENCE_WINDOW_MS * CLK_HZ / 1000;
    localparam longint PASS_WINDOW_CYC = PASS_WINDOW_MS * CLK_HZ / 1000;
    localparam longint SLAVE_ACTIVE_HOLD_CYC = SLAVE_ACTIVE_HOLD_MS * CLK_HZ / 1000;

endpackage

/* design/cadp_dec_if.sv */
// Carrier between the pin block and its address decoder.
interface cadp_dec_if;
    import cadp_pkg::*;

    cadp_mode_t mode;
    logic [ADDR_W-1:0] addr;
    logic attr_sel_n;
    logic io_access;
    logic sel0_n;
    logic sel1_n;
    cadp_space_t space;
    logic [ADDR_W-1:0] offset;

    modport requester (
        output mode, addr, attr_sel_n, io_access, sel0_n, sel1_n,
        input space, offset
    );

    modport decoder (
        input mode, addr, attr_sel_n, io_access, sel0_n, sel1_n,
        output space, offset
    );
endinterface

/* design/cadp_addr_dec.sv */
// Combinational address decoder for all three host modes.
module cadp_addr_dec
    import cadp_pkg::*;
(
    cadp_dec_if.decoder dec
);

    always_comb begin
        dec.space = SPACE_NONE;
        dec.offset = '0;
        unique case (dec.mode)
            MODE_PC_MEMORY, MODE_PC_IO: begin
                if (!dec.sel0_n || !dec.sel1_n) begin
                    dec.offset = dec.addr;
                    if (dec.mode == MODE_PC_IO && dec.io_access && !dec.attr_sel_n) begin
                        dec.space = SPACE_IO_REGS;
                    end else if (dec.attr_sel_n) begin
                        dec.space = SPACE_MEMORY_REGS;
                    end else if (dec.addr < CONFIG_SPACE_BASE) begin
                        dec.space = SPACE_CARD_INFO;
                    end else begin
                        dec.space = SPACE_CONFIG_STATUS;
                    end
                end
            end
            MODE_IDE_COMPATIBLE: begin
                // Upper address lines never reach the offset in this mode.
                dec.offset = {{(ADDR_W-TF_IDX_W){1'b0}}, dec.addr[TF_IDX_W-1:0]};
                if (!dec.sel0_n && dec.sel1_n) begin
                    dec.space = SPACE_TASKFILE;
                end else if (dec.sel0_n && !dec.sel1_n
                             && dec.addr[TF_IDX_W-1:1] == CTRL_ALT_STATUS_IDX[2:1]) begin
                    dec.space = SPACE_CONTROL_BLOCK;
                end
            end
            default: begin
                dec.space = SPACE_NONE;
            end
        endcase
    end

endmodule

/* design/cadp_pins.sv */
// Address decode, fixed pins, status-change and master/slave handshake pins.
module cadp_pins
    import cadp_pkg::*;
#(
    parameter longint PRESENCE_WINDOW = PRESENCE_WINDOW_CYC,
    parameter longint PASS_WINDOW = PASS_WINDOW_CYC,
    parameter longint SLAVE_ACTIVE_HOLD = SLAVE_ACTIVE_HOLD_CYC
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Mode and host address side
    input wire logic [1:0] card_mode,
    input wire logic [ADDR_W-1:0] host_addr,
    input wire logic attr_sel_n,
    input wire logic io_access,
    input wire logic taskfile_select_n,
    input wire logic control_block_select_n,
    // Decode result
    output logic [2:0] dec_space,
    output logic [ADDR_W-1:0] dec_offset,
    // Core state for status change
    input wire logic ready_busy_state,
    input wire logic write_protect_state,
    input wire logic io_configured,
    input wire logic status_change_enable,
    input wire logic status_change_clear,
    output logic status_change_pending,
    // Pin 46: battery status one, status changed, pass diagnostic
    input wire logic diag_status_pin_i,
    output logic diag_status_pin_o,
    output logic diag_status_pin_oe,
    // Pin 45: battery status two, audio, drive active / slave present
    input wire logic active_audio_pin_i,
    output logic active_audio_pin_o,
    output logic active_audio_pin_oe,
    // Insertion detect pins
    output logic [1:0] insertion_detect_n,
    // Master/slave handshake, core side
    input wire logic cable_select_n,
    input wire logic handshake_start,
    input wire logic diag_done,
    input wire logic diag_passed,
    input wire logic drive_active,
    output logic slave_present,
    output logic slave_diag_passed,
    output logic handshake_done
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode.

    cadp_dec_if dec_bus ();
    cadp_mode_t mode;
    cadp_space_t space_d;
    cadp_space_t space_q;
    logic [ADDR_W-1:0] offset_q;

    assign mode = cadp_mode_t'(card_mode);
    assign dec_bus.mode = mode;
    assign dec_bus.addr = host_addr;
    assign dec_bus.attr_sel_n = attr_sel_n;
    assign dec_bus.io_access = io_access;
    assign dec_bus.sel0_n = taskfile_select_n;
    assign dec_bus.sel1_n = control_block_select_n;
    assign space_d = dec_bus.space;

    cadp_addr_dec u_dec (
        .dec(dec_bus)
    );

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            space_q <= SPACE_NONE;
            offset_q <= '0;
        end else begin
            space_q <= space_d;
            offset_q <= dec_bus.offset;
        end
    end

    assign dec_space = space_q;
    assign dec_offset = offset_q;

    ////////////////////////////////////////////////////////////////////////
    // Status change detection.

    logic rdy_prev_q;
    logic rdy_prev_d;
    logic wp_prev_q;
    logic wp_prev_d;
    logic changed_q;
    logic changed_d;
    logic notify_n_q;
    logic notify_n_d;
    logic status_changed_n;

    always_comb begin
        rdy_prev_d = ready_busy_state;
        wp_prev_d = write_protect_state;
        changed_d = changed_q;
        if (status_change_clear) begin
            changed_d = 1'b0;
        end
        // A change in the clearing cycle still sets the flag.
        if (rdy_prev_q != ready_busy_state || wp_prev_q != write_protect_state) begin
            changed_d = 1'b1;
        end
        notify_n_d = !(changed_q && status_change_enable && io_configured);
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdy_prev_q <= 1'b0;
            wp_prev_q <= 1'b0;
            changed_q <= 1'b0;
            notify_n_q <= 1'b1;
        end else begin
            rdy_prev_q <= rdy_prev_d;
            wp_prev_q <= wp_prev_d;
            changed_q <= changed_d;
            notify_n_q <= notify_n_d;
        end
    end

    assign status_changed_n = notify_n_q;
    assign status_change_pending = changed_q;

    ////////////////////////////////////////////////////////////////////////
    // Master/slave handshake.

    cadp_hs_t hs_q;
    cadp_hs_t hs_d;
    logic [TIMER_W-1:0] timer_q;
    logic [TIMER_W-1:0] timer_d;
    logic is_master_q;
    logic is_master_d;
    logic slave_present_q;
    logic slave_present_d;
    logic slave_ok_q;
    logic slave_ok_d;
    logic pass_drive_q;
    logic pass_drive_d;
    logic active_drive_q;
    logic active_drive_d;
    logic ide_mode;

    assign ide_mode = (mode == MODE_IDE_COMPATIBLE);

    always_comb begin
        hs_d = hs_q;
        timer_d = timer_q + 1'b1;
        is_master_d = is_master_q;
        slave_present_d = slave_present_q;
        slave_ok_d = slave_ok_q;
        pass_drive_d = pass_drive_q;
        active_drive_d = active_drive_q;
        if (!ide_mode) begin
            hs_d = HS_IDLE;
            timer_d = '0;
            pass_drive_d = 1'b0;
            active_drive_d = 1'b0;
        end else if (handshake_start) begin
            // Strap is caught here, after reset has gone.
            is_master_d = !cable_select_n;
            timer_d = '0;
            slave_present_d = 1'b0;
            slave_ok_d = 1'b0;
            pass_drive_d = 1'b0;
            active_drive_d = cable_select_n;
            hs_d = cable_select_n ? HS_SLAVE_ANNOUNCE : HS_MASTER_WAIT_PRESENT;
        end else begin
            unique case (hs_q)
                HS_IDLE: begin
                    timer_d = '0;
                end
                HS_SLAVE_ANNOUNCE: begin
                    if (diag_done) begin
                        pass_drive_d = diag_passed;
                    end
                    if (diag_done || timer_q >= TIMER_W'(SLAVE_ACTIVE_HOLD - 1)) begin
                        active_drive_d = 1'b0;
                        hs_d = HS_DONE;
                    end
                end
                HS_MASTER_WAIT_PRESENT: begin
                    if (!active_audio_pin_i) begin
                        slave_present_d = 1'b1;
                        timer_d = '0;
                        hs_d = HS_MASTER_WAIT_PASS;
                    end else if (timer_q >= TIMER_W'(PRESENCE_WINDOW - 1)) begin
                        hs_d = HS_DONE;
                    end
                end
                HS_MASTER_WAIT_PASS: begin
                    if (!diag_status_pin_i) begin
                        slave_ok_d = 1'b1;
                        hs_d = HS_DONE;
                    end else if (timer_q >= TIMER_W'(PASS_WINDOW - 1)) begin
                        hs_d = HS_DONE;
                    end
                end
                HS_DONE: begin
                    timer_d = timer_q;
                    active_drive_d = drive_active;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hs_q <= HS_IDLE;
            timer_q <= '0;
            is_master_q <= 1'b0;
            slave_present_q <= 1'b0;
            slave_ok_q <= 1'b0;
            pass_drive_q <= 1'b0;
            active_drive_q <= 1'b0;
        end else begin
            hs_q <= hs_d;
            timer_q <= timer_d;
            is_master_q <= is_master_d;
            slave_present_q <= slave_present_d;
            slave_ok_q <= slave_ok_d;
            pass_drive_q <= pass_drive_d;
            active_drive_q <= active_drive_d;
        end
    end

    assign slave_present = slave_present_q;
    assign slave_diag_passed = slave_ok_q;
    assign handshake_done = (hs_q == HS_DONE);

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers.

    always_comb begin
        diag_status_pin_o = 1'b1;
        diag_status_pin_oe = 1'b0;
        active_audio_pin_o = 1'b1;
        active_audio_pin_oe = 1'b0;
        unique case (mode)
            MODE_PC_MEMORY: begin
                diag_status_pin_oe = 1'b1;
                active_audio_pin_oe = 1'b1;
            end
            MODE_PC_IO: begin
                diag_status_pin_o = status_changed_n;
                diag_status_pin_oe = 1'b1;
                active_audio_pin_oe = 1'b1;
            end
            MODE_IDE_COMPATIBLE: begin
                // Both handshake lines are open drain: only ever pulled low.
                diag_status_pin_o = 1'b0;
                diag_status_pin_oe = pass_drive_q && !is_master_q;
                active_audio_pin_o = 1'b0;
                active_audio_pin_oe = active_drive_q;
            end
            default: begin
                diag_status_pin_oe = 1'b0;
            end
        endcase
    end

    assign insertion_detect_n = INSERTION_DETECT_LEVEL;

endmodule

/* verification/cadp_pins_assertions.sv */
// Port checks for the pin block.
module cadp_pins_assertions
    import cadp_pkg::*;
(
    // Clock, reset and decode
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [1:0] card_mode,
    input wire logic [ADDR_W-1:0] host_addr,
    input wire logic attr_sel_n,
    input wire logic taskfile_select_n,
    input wire logic control_block_select_n,
    input wire logic [2:0] dec_space,
    input wire logic [ADDR_W-1:0] dec_offset,
    // Status change and pins
    input wire logic ready_busy_state,
    input wire logic io_configured,
    input wire logic status_change_enable,
    input wire logic status_change_clear,
    input wire logic status_change_pending,
    input wire logic diag_status_pin_o,
    input wire logic diag_status_pin_oe,
    input wire logic active_audio_pin_o,
    input wire logic active_audio_pin_oe,
    input wire logic [1:0] insertion_detect_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire [2:0] low_addr = host_addr[2:0];
    sequence s_pc_sel;
        card_mode < 2'h2 && !taskfile_select_n;
    endsequence
    sequence s_notify;
        status_change_pending ##1 !diag_status_pin_o;
    endsequence
    a_mem_space: assert property (s_pc_sel ##0 attr_sel_n |=> dec_space == 3'h3)
        else $error("memory decode");
    a_attr_space: assert property (s_pc_sel ##0 !attr_sel_n && card_mode == 2'h0
        |=> dec_space == ($past(host_addr) < CONFIG_SPACE_BASE ? 3'h1 : 3'h2))
        else $error("attribute decode");
    a_ide_taskfile: assert property (card_mode == 2'h2 && !taskfile_select_n
        && control_block_select_n |=> dec_space == 3'h5 && dec_offset == {8'h00, $past(low_addr)})
        else $error("task file decode");
    a_ide_control: assert property (card_mode == 2'h2 && taskfile_select_n
        && !control_block_select_n && host_addr[2:1] == 2'h3 |=> dec_space == 3'h6)
        else $error("control decode");
    a_batt_one: assert property (card_mode == 2'h0
        |-> diag_status_pin_oe && diag_status_pin_o) else $error("battery one");
    a_batt_two: assert property (card_mode == 2'h0
        |-> active_audio_pin_oe && active_audio_pin_o) else $error("battery two");
    a_audio_high: assert property (card_mode == 2'h1
        |-> active_audio_pin_oe && active_audio_pin_o) else $error("audio pin");
    a_detect_low: assert property (insertion_detect_n == 2'h0)
        else $error("insertion detect");
    a_change_notify: assert property ($changed(ready_busy_state) && card_mode == 2'h1
        && io_configured && status_change_enable && !status_change_clear |=> s_notify)
        else $error("status change");
endmodule

/* verification/cadp_peer_drive.sv */
// Peer drive on the shared handshake lines, with their pull-ups.
module cadp_peer_drive
(
    // Device side and peer commands
    input wire logic act_o,
    input wire logic act_oe,
    input wire logic pass_o,
    input wire logic pass_oe,
    input wire logic peer_act,
    input wire logic peer_pass,
    // Line levels
    output logic act_line,
    output logic pass_line
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released lines read high through the pull-ups.
    assign act_line = (act_oe ? act_o : 1'b1) & !peer_act;
    assign pass_line = (pass_oe ? pass_o : 1'b1) & !peer_pass;
endmodule

/* verification/cadp_pins_tb.sv */
// Self-checking bench for the pin block.
module cadp_pins_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, attr_n = 1'b1, io = 1'b0, tf_n = 1'b1, cb_n = 1'b1;
    logic rdy = 1'b0, wp = 1'b0, cfg = 1'b0, en = 1'b0, clr = 1'b0, csel_n = 1'b1;
    logic start = 1'b0, dd = 1'b0, dp = 1'b0, act = 1'b0, pr_act = 1'b0, pr_pass = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [10:0] addr = 11'h000;
    logic [2:0] space;
    logic [10:0] offset;
    logic pend, p46_o, p46_oe, p45_o, p45_oe, present, passed, hs_done, line45, line46;
    logic [1:0] det_n;
    int mismatches = 0;
    int checked = 0;
    cadp_pins #(.PRESENCE_WINDOW(20), .PASS_WINDOW(40), .SLAVE_ACTIVE_HOLD(30)) cadp_pins_inst (
        .core_clk(clk), .sys_rst(rst), .card_mode(mode), .host_addr(addr), .attr_sel_n(attr_n),
        .io_access(io), .taskfile_select_n(tf_n), .control_block_select_n(cb_n),
        .dec_space(space), .dec_offset(offset), .ready_busy_state(rdy),
        .write_protect_state(wp), .io_configured(cfg), .status_change_enable(en),
        .status_change_clear(clr), .status_change_pending(pend), .diag_status_pin_i(line46),
        .diag_status_pin_o(p46_o), .diag_status_pin_oe(p46_oe), .active_audio_pin_i(line45),
        .active_audio_pin_o(p45_o), .active_audio_pin_oe(p45_oe), .insertion_detect_n(det_n),
        .cable_select_n(csel_n), .handshake_start(start), .diag_done(dd), .diag_passed(dp),
        .drive_active(act), .slave_present(present), .slave_diag_passed(passed),
        .handshake_done(hs_done)
    );
    cadp_peer_drive cadp_peer_drive_inst (.act_o(p45_o), .act_oe(p45_oe), .pass_o(p46_o),
        .pass_oe(p46_oe), .peer_act(pr_act), .peer_pass(pr_pass), .act_line(line45),
        .pass_line(line46));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Upper address bits stay grounded in the IDE cases.
    task automatic dec(input logic [1:0] m, input logic a, i, s0, s1, input logic [10:0] ad,
                       input logic [2:0] sp);
        @(posedge clk);
        mode <= m;
        attr_n <= a;
        io <= i;
        tf_n <= s0;
        cb_n <= s1;
        addr <= ad;
        settle(1);
        chk(11'(space), 11'(sp));
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_decode();
        dec(2'h0, 1'b1, 1'b0, 1'b0, 1'b1, 11'h7ff, 3'h3);
        dec(2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 11'h1ff, 3'h1);
        dec(2'h1, 1'b0, 1'b0, 1'b0, 1'b0, 11'h200, 3'h2);
        dec(2'h1, 1'b0, 1'b1, 1'b0, 1'b1, 11'h3a5, 3'h4);
        for (int k = 0; k < 8; k++) begin
            dec(2'h2, 1'b1, 1'b0, 1'b0, 1'b1, 11'(k), 3'h5);
            chk(offset, 11'(k));
        end
        dec(2'h2, 1'b1, 1'b0, 1'b1, 1'b0, 11'h006, 3'h6);
        dec(2'h2, 1'b1, 1'b0, 1'b1, 1'b0, 11'h002, 3'h0);
        dec(2'h2, 1'b1, 1'b0, 1'b0, 1'b0, 11'h006, 3'h0);
    endtask
    task automatic t_fixed();
        for (int m = 0; m < 4; m++) begin
            @(posedge clk);
            mode <= 2'(m);
            settle(1);
            chk(11'(det_n), 11'h000);
            if (m == 0) chk({p46_oe, p46_o, p45_oe, p45_o}, 11'h00f);
            if (m == 1) chk({p45_oe, p45_o}, 11'h003);
            if (m == 3) chk({p46_oe, p45_oe}, 11'h000);
        end
    endtask
    task automatic t_status();
        @(posedge clk);
        mode <= 2'h1;
        cfg <= 1'b1;
        en <= 1'b1;
        rdy <= 1'b1;
        settle(1);
        chk(11'(pend), 11'h001);
        settle(1);
        chk({p46_oe, line46}, 11'h002);
        @(posedge clk);
        en <= 1'b0;
        wp <= 1'b1;
        settle(3);
        chk({pend, line46}, 11'h003);
        // A clear alone drops the flag; a change in the clearing cycle keeps it.
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        #1;
        chk(11'(pend), 11'h000);
        @(posedge clk);
        clr <= 1'b1;
        rdy <= 1'b0;
        @(posedge clk);
        clr <= 1'b0;
        #1;
        chk({pend, line46}, 11'h003);
    endtask
    task automatic t_slave();
        @(posedge clk);
        mode <= 2'h2;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        #1;
        chk(11'(line45), 11'h000);
        @(posedge clk);
        dd <= 1'b1;
        dp <= 1'b1;
        @(posedge clk);
        dd <= 1'b0;
        #1;
        chk({hs_done, line45, line46}, 11'h006);
    endtask
    task automatic t_master();
        @(posedge clk);
        mode <= 2'h1;
        @(posedge clk);
        mode <= 2'h2;
        csel_n <= 1'b0;
        pr_act <= 1'b1;
        pr_pass <= 1'b1;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (int k = 0; k < 200 && hs_done !== 1'b1; k++) settle(1);
        if (hs_done !== 1'b1) begin
            mismatches++;
            results();
        end
        chk({present, passed, p46_oe}, 11'h006);
        @(posedge clk);
        act <= 1'b1;
        settle(1);
        chk({p45_oe, p45_o}, 11'h002);
    endtask
    // Handshake with a silent or half-silent peer: the wait must end on its window.
    task automatic t_lone(input logic cs_n, pd, input logic [10:0] win, flags);
        int n;
        @(posedge clk);
        mode <= 2'h1;
        act <= 1'b0;
        pr_act <= pd;
        pr_pass <= 1'b0;
        @(posedge clk);
        mode <= 2'h2;
        csel_n <= cs_n;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (n = 0; n < 200 && hs_done !== 1'b1; n++) settle(1);
        if (hs_done !== 1'b1) begin
            mismatches++;
            results();
        end
        chk(11'(n), win);
        chk({present, passed, line45, line46}, flags);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_decode();
        t_fixed();
        t_status();
        t_slave();
        t_master();
        t_lone(1'b0, 1'b0, 11'h014, 11'h003);
        t_lone(1'b0, 1'b1, 11'h029, 11'h009);
        t_lone(1'b1, 1'b0, 11'h01e, 11'h003);
        results();
    end
endmodule
bind cadp_pins cadp_pins_assertions cadp_pins_assertions_inst (.core_clk, .sys_rst, .card_mode,
    .host_addr, .attr_sel_n, .taskfile_select_n, .control_block_select_n, .dec_space,
    .dec_offset, .ready_busy_state, .io_configured, .status_change_enable,
    .status_change_clear, .status_change_pending, .diag_status_pin_o, .diag_status_pin_oe,
    .active_audio_pin_o, .active_audio_pin_oe, .insertion_detect_n);
